// ---- core_model.sv ----
// Stand-in for the processor core: wait instruction and interrupt line.
// Assumes the bench raises i_go for one cycle to ask for a wait.
`timescale 1ns/1ps
module core_model (
   input wire logic i_sys_clk,
   input wire logic i_go,
   input wire logic [3:0] i_irq_delay,
   input wire logic i_cpu_clk_en,
   output logic o_wait_instr,
   output logic o_core_irq
);
   logic [3:0] cnt_q;
   initial begin
      o_wait_instr = 1'h0;
      o_core_irq = 1'h0;
      cnt_q = 4'h0;
   end
   // Interrupt only counts while the CPU clock is off, so a slow wake is exercised
   always @(posedge i_sys_clk) begin
      o_wait_instr <= i_go;
      if (i_cpu_clk_en === 1'h1) begin
         cnt_q <= 4'h0;
         o_core_irq <= 1'h0;
      end else if (i_irq_delay != 4'h0) begin
         cnt_q <= cnt_q + 4'h1;
         if (cnt_q == i_irq_delay) begin
            o_core_irq <= 1'h1;
         end
      end
   end
endmodule : core_model

// ---- power_mode_wakeup_controller_bench.sv ----
// Self-checking bench of the power mode and wakeup controller.
// Assumes the core stand-in and a 10 MHz clock.
`timescale 1ns/1ps
`include "pwr_wake_map.svh"
module power_mode_wakeup_controller_bench;
   import pwr_wake_pkg::*;
   logic i_sys_clk = 1'h0;
   logic i_rst = 1'h1;
   avmm_req_type avmm = '0;
   logic [31:0] rdata;
   logic wreq;
   logic [111:0] gpio = '0;
   logic below = 1'h0;
   logic pwr_dn = 1'h0;
   logic wake_pin = 1'h0;
   logic rst_pin = 1'h0;
   logic wdog = 1'h0;
   logic alarm = 1'h0;
   logic usb_wk = 1'h0;
   logic osc_fail = 1'h0;
   logic go = 1'h0;
   logic [1:0] boot = 2'h0;
   logic bank2 = 1'h1;
   logic [3:0] irq_dly = 4'h0;
   logic wait_i, core_irq, clk_ext, cf_irq, svd_irq, boot_b2, ls_run;
   logic [18:0] irq_req, evt_req;
   pwr_out_type pwr;
   boot_src_type boot_src;
   int failures = 0;
   int comparisons = 0;
   int evt_cnt = 0;
   integer seed = 32'hb86f7914;
   logic [31:0] expq[$];
   logic [6:0] pin;

   always #50 i_sys_clk = ~i_sys_clk;

   pwr_wake_ctrl uut (
      .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_avmm(avmm),
      .o_readdata(rdata), .o_waitrequest(wreq), .i_gpio(gpio),
      .i_cal_alarm(alarm), .i_usb_wakeup(usb_wk), .i_supply_below(below),
      .i_power_down_reset(pwr_dn), .i_reset_pin_low(rst_pin),
      .i_independent_watchdog(wdog), .i_wakeup_pin(wake_pin),
      .i_ext_osc_fail(osc_fail), .i_wait_instr(wait_i),
      .i_core_irq(core_irq), .i_boot_pins(boot), .i_bank2_opt(bank2),
      .o_irq_req(irq_req), .o_evt_req(evt_req), .o_clk_fail_irq(cf_irq),
      .o_svd_irq(svd_irq), .o_sys_clk_ext(clk_ext), .o_lowspeed_run(ls_run),
      .o_pwr(pwr), .o_boot_src(boot_src), .o_boot_bank2(boot_b2)
   );

   core_model partner (
      .i_sys_clk(i_sys_clk), .i_go(go), .i_irq_delay(irq_dly),
      .i_cpu_clk_en(pwr.cpu_clk_en), .o_wait_instr(wait_i),
      .o_core_irq(core_irq)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task give_verdict;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict

   task automatic step(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask : step

   // Request held until the edge that sees waitrequest low
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge i_sys_clk);
      avmm <= '{read: !wr, write: wr, address: a, byteenable: 4'hf,
                writedata: d};
      do begin
         @(posedge i_sys_clk);
      end while (wreq !== 1'h0);
      avmm <= '0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(1'h0, a, 32'h0);
   endtask : rd

   task automatic wfi;
      go <= 1'h1;
      step(1);
      go <= 1'h0;
   endtask : wfi

   // Read data is judged where the master takes it
   always @(posedge i_sys_clk) begin
      if (avmm.read && wreq === 1'h0) begin
         chk(rdata, expq.pop_front());
      end
      if (evt_req[0] === 1'h1) begin
         evt_cnt++;
      end
   end

   initial begin
      #1000000;
      failures++;
      $display("FAIL %0t timeout", $time);
      give_verdict();
   end

   initial begin
      pin = 7'({$random(seed)} % 112);
      repeat (10) @(posedge i_sys_clk);
      i_rst <= 1'h0;
      step(2);
      chk(32'(pwr), 32'h3e);
      chk(32'(clk_ext), 32'h0);
      chk(32'(boot_src), 32'(BOOT_FLASH));
      chk(32'(boot_b2), 32'h1);
      rd(`OFF_CTRL, 32'(`RST_CTRL));
      rd(8'h3c, 32'h0);
      wr(8'h40, {25'h0, pin});
      rd(8'h40, {25'h0, pin});
      wr(`OFF_EMASK, 32'h1);
      for (int m = 1; m < 4; m++) begin
         int base;
         base = evt_cnt;
         wr(`OFF_RISE, 32'(m & 1));
         wr(`OFF_FALL, 32'(m >> 1));
         gpio[pin] <= 1'h1;
         step(1);
         gpio[pin] <= 1'h0;
         step(4);
         chk(32'(evt_cnt - base), (m == 3) ? 32'h2 : 32'h1);
      end
      chk(32'(irq_req), 32'h0);
      wr(`OFF_PEND, 32'h7ffff);
      wr(`OFF_IMASK, 32'h1);
      gpio[pin] <= 1'h1;
      step(3);
      chk(32'(irq_req), 32'h1);
      rd(`OFF_PEND, 32'h1);
      wr(`OFF_PEND, 32'h1);
      step(2);
      chk(32'(irq_req), 32'h0);
      gpio[pin] <= 1'h0;
      step(3);
      wr(`OFF_PEND, 32'h1);
      wr(`OFF_CTRL, 32'h0c);
      step(2);
      chk(32'(clk_ext), 32'h1);
      osc_fail <= 1'h1;
      step(3);
      chk(32'(clk_ext), 32'h0);
      chk(32'(cf_irq), 32'h1);
      osc_fail <= 1'h0;
      wr(`OFF_STAT, 32'h1);
      step(2);
      chk(32'(cf_irq), 32'h0);
      below <= 1'h1;
      step(3);
      chk(32'(svd_irq), 32'h0);
      below <= 1'h0;
      wr(`OFF_CTRL, 32'hd0);
      below <= 1'h1;
      step(3);
      chk(32'(svd_irq), 32'h1);
      below <= 1'h0;
      wr(`OFF_STAT, 32'h2);
      step(2);
      chk(32'(svd_irq), 32'h0);
      wr(`OFF_CTRL, 32'h0);
      irq_dly <= 4'h5;
      wfi();
      step(3);
      chk(32'(pwr), 32'h1e);
      step(12);
      chk(32'(pwr), 32'h3e);
      irq_dly <= 4'h0;
      wr(`OFF_CTRL, 32'h1);
      wfi();
      step(3);
      chk(32'(pwr), 32'h06);
      gpio[pin] <= 1'h1;
      step(5);
      chk(32'(pwr), 32'h3e);
      rd(`OFF_CTRL, 32'h1);
      gpio[pin] <= 1'h0;
      wr(`OFF_CTRL, 32'h3);
      wfi();
      step(3);
      chk(32'(pwr), 32'h01);
      wake_pin <= 1'h1;
      step(6);
      chk(32'(pwr), 32'h3e);
      rd(`OFF_EMASK, 32'h0);
      wake_pin <= 1'h0;
      // Wake from stop by the bus wakeup line
      wr(`OFF_RISE, 32'h40000);
      wr(`OFF_IMASK, 32'h40000);
      wr(`OFF_CTRL, 32'h1);
      wfi();
      step(3);
      chk(32'(pwr), 32'h06);
      usb_wk <= 1'h1;
      step(5);
      chk(32'(pwr), 32'h3e);
      chk(32'(irq_req), 32'h40000);
      usb_wk <= 1'h0;
      // Standby left by the calendar alarm
      wr(`OFF_CTRL, 32'h3);
      wfi();
      step(3);
      chk(32'(pwr), 32'h01);
      chk(32'(ls_run), 32'h1);
      alarm <= 1'h1;
      step(6);
      chk(32'(pwr), 32'h3e);
      alarm <= 1'h0;
      // Watchdog restart must not resample the boot pins
      wr(`OFF_CTRL, 32'h3);
      wfi();
      step(3);
      chk(32'(pwr), 32'h01);
      boot <= 2'h1;
      wdog <= 1'h1;
      step(2);
      chk(32'(pwr), 32'h0f);
      wdog <= 1'h0;
      step(2);
      chk(32'(pwr), 32'h3e);
      chk(32'(boot_src), 32'(BOOT_FLASH));
      wr(`OFF_CTRL, 32'h3);
      wfi();
      step(3);
      chk(32'(pwr), 32'h01);
      rst_pin <= 1'h1;
      step(2);
      chk(32'(pwr), 32'h0f);
      rst_pin <= 1'h0;
      step(3);
      chk(32'(boot_src), 32'(BOOT_SYSMEM));
      chk(32'(boot_b2), 32'h0);
      boot <= 2'h3;
      pwr_dn <= 1'h1;
      step(3);
      chk(32'(pwr), 32'h0f);
      pwr_dn <= 1'h0;
      step(3);
      chk(32'(boot_src), 32'(BOOT_SRAM));
      chk(32'(pwr), 32'h3e);
      give_verdict();
   end
endmodule : power_mode_wakeup_controller_bench

// ---- pwr_wake_ctrl.sv ----
// Power mode, wakeup, edge event, clock fallback and boot controller.
// Assumes i_sys_clk is always-on and all pin inputs are synchronous.
//
// Contract
// - Nineteen independent edge lines, each raising interrupt or event requests.
// - Each line selects rising, falling or both edges.
// - Each line has its own mask; masked edges are not forwarded.
// - Pending register has one bit per line for interrupt requests.
// - Pulses shorter than a peripheral clock period are still caught.
// - Sixteen external lines, each sourced from any of 112 pins.
// - After reset the processor runs on the internal 8 MHz oscillator.
// - External clock is monitored; failure switches back to internal oscillator.
// - Clock failure raises an interrupt when enabled.
// - Device held in reset while supply is below threshold.
// - Supply detector interrupts on falling, rising or either crossing.
// - Regulator main mode in Run and Stop; off in Standby.
// - Regulator enabled after reset, disabled only in Standby.
// - Sleep stops only the processor clock; any interrupt or event wakes.
// - Stop gates core clocks and oscillators, keeping memory contents.
// - Any edge line unmasked for interrupt or event wakes the device from Stop.
// - Standby powers off the core; its state is lost.
// - Standby exits on reset pin, watchdog, wakeup rise or alarm.
// - Calendar and watchdog clocks keep running in Stop and Standby.
// - Boot pins sampled at startup choose flash, system memory or SRAM.
// - Flash boot uses bank 1 unless the bank-2 option bit is set.
`timescale 1ns/1ps
`include "pwr_wake_map.svh"
module pwr_wake_ctrl (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire pwr_wake_pkg::avmm_req_type i_avmm,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   input wire logic [`N_PINS-1:0] i_gpio,
   input wire logic i_cal_alarm,
   input wire logic i_usb_wakeup,
   input wire logic i_supply_below,
   input wire logic i_power_down_reset,
   input wire logic i_reset_pin_low,
   input wire logic i_independent_watchdog,
   input wire logic i_wakeup_pin,
   input wire logic i_ext_osc_fail,
   input wire logic i_wait_instr,
   input wire logic i_core_irq,
   input wire logic [1:0] i_boot_pins,
   input wire logic i_bank2_opt,
   output logic [`N_LINES-1:0] o_irq_req,
   output logic [`N_LINES-1:0] o_evt_req,
   output logic o_clk_fail_irq,
   output logic o_svd_irq,
   output logic o_sys_clk_ext,
   output logic o_lowspeed_run,
   output pwr_wake_pkg::pwr_out_type o_pwr,
   output pwr_wake_pkg::boot_src_type o_boot_src,
   output logic o_boot_bank2
);
   import pwr_wake_pkg::*;

   function automatic logic [31:0] be_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : be_merge

   logic wake_rst_q;
   logic dev_rst;
   // Supply, pin and watchdog resets all restart the block
   assign dev_rst = i_rst | i_power_down_reset | i_reset_pin_low |
                    i_independent_watchdog | wake_rst_q;

   // Bus slave: one wait cycle, answer on the second edge
   logic wait_q;
   logic req;
   logic acc;
   assign req = i_avmm.read | i_avmm.write;
   assign acc = req & ~wait_q;
   logic wr_ctrl, wr_stat, wr_imask, wr_emask, wr_rise, wr_fall, wr_pend;
   logic wr_psel;
   logic [7:0] adr;
   assign adr = i_avmm.address;
   assign wr_ctrl = acc & i_avmm.write & (adr == `OFF_CTRL);
   assign wr_stat = acc & i_avmm.write & (adr == `OFF_STAT);
   assign wr_imask = acc & i_avmm.write & (adr == `OFF_IMASK);
   assign wr_emask = acc & i_avmm.write & (adr == `OFF_EMASK);
   assign wr_rise = acc & i_avmm.write & (adr == `OFF_RISE);
   assign wr_fall = acc & i_avmm.write & (adr == `OFF_FALL);
   assign wr_pend = acc & i_avmm.write & (adr == `OFF_PEND);
   assign wr_psel = acc & i_avmm.write & (adr[7:6] == `PSEL_PAGE);
   logic [3:0] psel_idx;
   assign psel_idx = adr[5:2];

   ctrl_type ctrl_q, ctrl_d, ctrl_w;
   logic [`N_LINES-1:0] imask_q, emask_q, rise_q, fall_q, pend_q, pend_d;
   logic [`PSEL_W-1:0] psel_q [`N_EXT];
   logic [31:0] wmerge_ctrl, wmerge_pend;
   assign wmerge_ctrl = be_merge(32'h0, i_avmm.writedata, i_avmm.byteenable);
   assign wmerge_pend = be_merge(32'h0, i_avmm.writedata, i_avmm.byteenable);
   logic [31:0] ctrl_merge;
   assign ctrl_merge = be_merge({24'h0, ctrl_q}, i_avmm.writedata,
                                i_avmm.byteenable);
   assign ctrl_w = wr_ctrl ? ctrl_type'(ctrl_merge[7:0]) : ctrl_q;

   // Line sources and edge detection
   logic [`N_LINES-1:0] line_in, line_prev_q, line_rise, line_fall, trig;
   logic svd_level;
   assign svd_level = ctrl_q.svd_en & i_supply_below;
   genvar g;
   generate
      for (g = 0; g < `N_EXT; g++) begin : g_src
         assign line_in[g] = (psel_q[g] < `PSEL_W'(`N_PINS)) ?
                             i_gpio[psel_q[g]] : 1'b0;
      end
   endgenerate
   assign line_in[`LINE_SVD] = svd_level;
   assign line_in[`LINE_ALARM] = i_cal_alarm;
   assign line_in[`LINE_USB] = i_usb_wakeup;
   // Fast system clock samples, so sub-period APB2 pulses are seen
   assign line_rise = line_in & ~line_prev_q;
   assign line_fall = ~line_in & line_prev_q;
   assign trig = (line_rise & rise_q) | (line_fall & fall_q);
   // Set wins over a same-cycle write-one clear
   assign pend_d = (pend_q & ~(wr_pend ? wmerge_pend[`N_LINES-1:0] :
                   `RST_LINES)) | (trig & imask_q);

   // Supply detector crossing
   logic svd_prev_q, svd_flag_q, clk_fail_q;
   logic svd_hit, clk_fail_hit;
   assign svd_hit = ctrl_q.svd_en & ((ctrl_q.svd_fall & svd_level &
                    ~svd_prev_q) | (ctrl_q.svd_rise & ~svd_level &
                    svd_prev_q));
   assign clk_fail_hit = ctrl_q.ext_clk & i_ext_osc_fail;
   always_comb begin
      ctrl_d = ctrl_w;
      if (clk_fail_hit) begin
         ctrl_d.ext_clk = 1'b0;
      end
   end

   // Power mode
   pwr_mode_type mode_q, mode_d;
   logic wk_prev_q, wake_sb, stop_wake, sleep_wake;
   assign stop_wake = |(trig & (imask_q | emask_q));
   assign sleep_wake = i_core_irq | stop_wake;
   assign wake_sb = (i_wakeup_pin & ~wk_prev_q) |
                    line_rise[`LINE_ALARM];
   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         PM_RUN: begin
            if (i_wait_instr) begin
               if (!ctrl_q.deep) begin
                  mode_d = PM_SLEEP;
               end else if (ctrl_q.standby) begin
                  mode_d = PM_STANDBY;
               end else begin
                  mode_d = PM_STOP;
               end
            end
         end
         PM_SLEEP: begin
            if (sleep_wake) begin
               mode_d = PM_RUN;
            end
         end
         PM_STOP: begin
            if (stop_wake) begin
               mode_d = PM_RUN;
            end
         end
         PM_STANDBY: begin
            mode_d = PM_STANDBY;
         end
         default: begin
            mode_d = PM_RUN;
         end
      endcase
   end

   logic [31:0] stat_word, rd_word;
   assign stat_word = {23'h0, o_boot_bank2, o_boot_src, mode_q,
                       svd_level, o_sys_clk_ext, svd_flag_q, clk_fail_q};
   assign rd_word =
      (adr == `OFF_CTRL) ? {24'h0, ctrl_q} :
      (adr == `OFF_STAT) ? stat_word :
      (adr == `OFF_IMASK) ? {13'h0, imask_q} :
      (adr == `OFF_EMASK) ? {13'h0, emask_q} :
      (adr == `OFF_RISE) ? {13'h0, rise_q} :
      (adr == `OFF_FALL) ? {13'h0, fall_q} :
      (adr == `OFF_PEND) ? {13'h0, pend_q} :
      (adr[7:6] == `PSEL_PAGE) ? {25'h0, psel_q[psel_idx]} : 32'h0;

   always_ff @(posedge i_sys_clk) begin
      if (dev_rst) begin
         wait_q <= 1'b1;
         o_waitrequest <= 1'b1;
         o_readdata <= 32'h0;
      end else begin
         wait_q <= ~(req & wait_q);
         o_waitrequest <= ~(req & wait_q);
         if (i_avmm.read & wait_q) begin
            o_readdata <= rd_word;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (dev_rst) begin
         ctrl_q <= `RST_CTRL;
         imask_q <= `RST_LINES;
         emask_q <= `RST_LINES;
         rise_q <= `RST_LINES;
         fall_q <= `RST_LINES;
         pend_q <= `RST_LINES;
         line_prev_q <= `RST_LINES;
      end else begin
         ctrl_q <= ctrl_d;
         if (wr_imask) imask_q <= wmerge_ctrl[`N_LINES-1:0];
         if (wr_emask) emask_q <= wmerge_ctrl[`N_LINES-1:0];
         if (wr_rise) rise_q <= wmerge_ctrl[`N_LINES-1:0];
         if (wr_fall) fall_q <= wmerge_ctrl[`N_LINES-1:0];
         pend_q <= pend_d;
         line_prev_q <= line_in;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      for (int i = 0; i < `N_EXT; i++) begin
         if (dev_rst) begin
            psel_q[i] <= `RST_PSEL;
         end else if (wr_psel && psel_idx == 4'(i)) begin
            psel_q[i] <= wmerge_ctrl[`PSEL_W-1:0];
         end
      end
   end

   // Status flags: hardware set wins over write-one clear
   always_ff @(posedge i_sys_clk) begin
      if (dev_rst) begin
         clk_fail_q <= 1'b0;
         svd_flag_q <= 1'b0;
         svd_prev_q <= 1'b0;
      end else begin
         clk_fail_q <= clk_fail_hit | (clk_fail_q &
                       ~(wr_stat & wmerge_ctrl[`STAT_CLKFAIL]));
         svd_flag_q <= svd_hit | (svd_flag_q &
                       ~(wr_stat & wmerge_ctrl[`STAT_SVD]));
         svd_prev_q <= svd_level;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (dev_rst) begin
         o_irq_req <= `RST_LINES;
         o_evt_req <= `RST_LINES;
         o_clk_fail_irq <= 1'b0;
         o_svd_irq <= 1'b0;
         o_sys_clk_ext <= 1'b0;
      end else begin
         o_irq_req <= pend_d & imask_q;
         o_evt_req <= trig & emask_q;
         o_clk_fail_irq <= (clk_fail_hit | clk_fail_q) &
                           ctrl_q.clk_fail_ie;
         o_svd_irq <= (svd_hit | svd_flag_q) & ctrl_q.svd_ie;
         o_sys_clk_ext <= ctrl_d.ext_clk;
      end
   end

   // Mode and power outputs; standby wake restarts like a reset
   always_ff @(posedge i_sys_clk) begin
      if (dev_rst) begin
         mode_q <= PM_RUN;
         wk_prev_q <= 1'b0;
         wake_rst_q <= 1'b0;
         o_pwr <= '{cpu_clk_en: 1'b0, core_clk_en: 1'b0, hs_osc_en: 1'b1,
                    reg_en: 1'b1, reg_main: 1'b1, core_rst: 1'b1};
      end else begin
         mode_q <= mode_d;
         wk_prev_q <= i_wakeup_pin;
         wake_rst_q <= (mode_q == PM_STANDBY) & wake_sb;
         o_pwr.cpu_clk_en <= (mode_q == PM_RUN);
         o_pwr.core_clk_en <= (mode_q == PM_RUN) |
                              (mode_q == PM_SLEEP);
         o_pwr.hs_osc_en <= (mode_q == PM_RUN) | (mode_q == PM_SLEEP);
         o_pwr.reg_en <= (mode_q != PM_STANDBY);
         o_pwr.reg_main <= (mode_q != PM_STANDBY);
         o_pwr.core_rst <= (mode_q == PM_STANDBY);
      end
   end

   // Low-speed calendar and watchdog clocks never gated
   always_ff @(posedge i_sys_clk) begin
      o_lowspeed_run <= 1'b1;
   end

   // Boot straps caught on the first edge after reset release
   logic boot_done_q;
   boot_src_type boot_dec;
   assign boot_dec = !i_boot_pins[0] ? BOOT_FLASH :
                     !i_boot_pins[1] ? BOOT_SYSMEM : BOOT_SRAM;
   always_ff @(posedge i_sys_clk) begin
      if (i_rst | i_power_down_reset | i_reset_pin_low) begin
         boot_done_q <= 1'b0;
         o_boot_src <= BOOT_FLASH;
         o_boot_bank2 <= 1'b0;
      end else if (!boot_done_q) begin
         boot_done_q <= 1'b1;
         o_boot_src <= boot_dec;
         o_boot_bank2 <= (boot_dec == BOOT_FLASH) & i_bank2_opt;
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (dev_rst);

   sequence deep_wait_s;
      (mode_q == PM_RUN) && i_wait_instr && ctrl_q.deep;
   endsequence
   sequence light_wait_s;
      (mode_q == PM_RUN) && i_wait_instr && !ctrl_q.deep;
   endsequence

   stop_entry_a: assert property (
      deep_wait_s ##0 !ctrl_q.standby |=> mode_q == PM_STOP)
      else $error("stop not entered on deep wait");
   sleep_entry_a: assert property (
      light_wait_s |=> mode_q == PM_SLEEP ##1 !o_pwr.cpu_clk_en)
      else $error("light wait did not give sleep");
   sleep_clocks_a: assert property (
      mode_q == PM_SLEEP |=> !o_pwr.cpu_clk_en && o_pwr.core_clk_en)
      else $error("sleep clock gating wrong");
   stop_clocks_a: assert property (
      mode_q == PM_STOP |=> !o_pwr.core_clk_en && !o_pwr.hs_osc_en
                            && o_pwr.reg_main)
      else $error("stop clock gating wrong");
   standby_reg_a: assert property (
      mode_q == PM_STANDBY |=> !o_pwr.reg_en && !o_pwr.reg_main)
      else $error("regulator on in standby");
   standby_hold_a: assert property (
      mode_q == PM_STANDBY && !wake_sb |=> mode_q == PM_STANDBY)
      else $error("standby left without wake source");
   stop_wake_a: assert property (
      mode_q == PM_STOP && stop_wake |=> mode_q == PM_RUN)
      else $error("stop not left on line edge");
   pend_set_a: assert property (
      |(trig & imask_q) |=> (pend_q & $past(trig & imask_q)) ==
                            $past(trig & imask_q))
      else $error("pending bit not set");
   mask_gate_a: assert property (
      ##1 (o_irq_req & ~$past(imask_q)) == `RST_LINES)
      else $error("masked line forwarded");
   clk_fallback_a: assert property (
      clk_fail_hit |=> !ctrl_q.ext_clk && !o_sys_clk_ext && clk_fail_q)
      else $error("no fallback to internal clock");
   clk_irq_a: assert property (
      clk_fail_hit && ctrl_q.clk_fail_ie && !wr_ctrl |=>
         o_clk_fail_irq [*2])
      else $error("clock failure interrupt missing");
   bus_answer_a: assert property (
      req && o_waitrequest && wait_q |=> !o_waitrequest)
      else $error("bus answer late");
   boot_hold_a: assert property (
      boot_done_q |=> $stable(o_boot_src) && $stable(o_boot_bank2))
      else $error("boot source changed after startup");
   reg_on_run_a: assert property (
      mode_q != PM_STANDBY |=> o_pwr.reg_en)
      else $error("regulator off outside standby");
   lowspeed_on_a: assert property (
      o_lowspeed_run)
      else $error("low-speed clocks gated");
endmodule : pwr_wake_ctrl

// ---- pwr_wake_map.svh ----
// Register map, field positions and sizes of the power/wakeup controller.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
`ifndef PWR_WAKE_MAP_SVH
`define PWR_WAKE_MAP_SVH
`define N_LINES 19
`define N_EXT 16
`define N_PINS 112
`define PSEL_W 7
`define LINE_SVD 16
`define LINE_ALARM 17
`define LINE_USB 18
`define OFF_CTRL 8'h00
`define OFF_STAT 8'h04
`define OFF_IMASK 8'h08
`define OFF_EMASK 8'h0c
`define OFF_RISE 8'h10
`define OFF_FALL 8'h14
`define OFF_PEND 8'h18
`define PSEL_PAGE 2'h1
`define STAT_CLKFAIL 0
`define STAT_SVD 1
`define RST_CTRL 8'h00
`define RST_LINES 19'h00000
`define RST_PSEL 7'h00
`endif

// ---- pwr_wake_pkg.sv ----
// Types of the power/wakeup controller.
// Assumes pwr_wake_map.svh for numbers.
package pwr_wake_pkg;
   typedef enum logic [1:0] {
      PM_RUN = 2'b00,
      PM_SLEEP = 2'b01,
      PM_STOP = 2'b11,
      PM_STANDBY = 2'b10
   } pwr_mode_type;
   typedef enum logic [1:0] {
      BOOT_FLASH = 2'h0,
      BOOT_SYSMEM = 2'h1,
      BOOT_SRAM = 2'h2
   } boot_src_type;
   typedef struct packed {
      logic svd_ie;
      logic svd_fall;
      logic svd_rise;
      logic svd_en;
      logic clk_fail_ie;
      logic ext_clk;
      logic standby;
      logic deep;
   } ctrl_type;
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } avmm_req_type;
   typedef struct packed {
      logic cpu_clk_en;
      logic core_clk_en;
      logic hs_osc_en;
      logic reg_en;
      logic reg_main;
      logic core_rst;
   } pwr_out_type;
endpackage : pwr_wake_pkg
